// ---- hdl/gdc_regs.sv ----
// Notes on behaviour
// - Blanking time comes from config bits 1..0: 4000, 2000, 1000 or 500 ns.
// - The blanking field only takes a written value while the device sits in Standby; a shutdown resets it in any mode.
// - Status bits 7..5 hold the cause of the last reset or shutdown; non-zero means lost.
// - Status bit 4 follows the supply overvoltage comparator.
// - Status bit 3 follows the supply undervoltage comparator.
// - Status bits 2 and 1 follow the thermal shutdown and thermal warning comparators.
// - Standby is output enable low with sleep select clear; with it set, Sleep.
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module gdc_regs
  import gdc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic      [1:0]    s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic      [31:0]   s_axi_rdata,
  output logic      [1:0]    s_axi_rresp,
  input  wire logic          supply_ov_cmp,
  input  wire logic          supply_uv_cmp,
  input  wire logic          temp_shutdown_cmp,
  input  wire logic          temp_warning_cmp,
  input  wire logic          output_enable,
  input  wire logic          undervoltage_shutdown,
  input  wire logic          sleep_shutdown,
  input  wire logic          thermal_shutdown,
  output logic      [7:0]    dead_time_cycles,
  output logic      [7:0]    blank_time_cycles,
  output logic               standby_mode,
  output logic               sleep_mode,
  output logic               irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [DT_W-1:0]  dead_time_select;
    logic [BL_W-1:0]  blanking_time_select;
    logic             sleep_select;
    logic [2:0]       reset_cause_code;
    logic [3:0]       flags;
    logic [2:0]       shdn_prev;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    gdc_mode_e        mode;
    logic [7:0]       dt_cyc;
    logic [7:0]       bl_cyc;
  } gdc_regs_s;

  localparam gdc_regs_s REGS_RST = '{
    dead_time_select:     CFG_RST[DT_LSB +: DT_W],
    blanking_time_select: CFG_RST[BL_LSB +: BL_W],
    sleep_select:         1'b0,
    reset_cause_code:     CAUSE_POR,
    flags:                4'h0,
    shdn_prev:            3'h0,
    irq_status:           5'h00,
    irq_mask:             5'h00,
    mode:                 MODE_STANDBY,
    dt_cyc:               DT_RST_CYC,
    bl_cyc:               BL_RST_CYC
  };

  gdc_regs_s        q;
  gdc_regs_s        d;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic             wr_fire;
  logic [AW-1:0]    wr_addr;
  logic [7:0]       wr_data;
  logic             wr_strb;
  logic             wr_ok;
  logic [AW-1:0]    rd_addr;
  logic [7:0]       rd_data;
  logic             rd_ok;
  logic [7:0]       status_byte;
  logic [2:0]       shdn_rise;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             wr_cfg;
  logic [DT_W-1:0]  wr_dt;
  logic [BL_W-1:0]  wr_bl;
  logic             oe_s;

  // ****************************************************************
  // time decoding
  // ****************************************************************
  function automatic logic [7:0] dt_cycles(input logic [DT_W-1:0] code);
    int ns;
    ns = DT_BASE_NS - DT_STEP_NS * int'(code);
    return 8'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [7:0] bl_cycles(input logic [BL_W-1:0] code);
    int ns;
    ns = BL_BASE_NS >> code;
    return 8'(ns / CLK_PERIOD_NS);
  endfunction

  // ****************************************************************
  // bus front and pin synchronisers
  // ****************************************************************
  gdc_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_fire       (wr_fire),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  assign pin_raw = {thermal_shutdown, sleep_shutdown, undervoltage_shutdown,
                    output_enable, temp_warning_cmp, temp_shutdown_cmp,
                    supply_uv_cmp, supply_ov_cmp};

  gdc_sync #(.W(PIN_W)) u_sync (
    .aclk (aclk),
    .din  (pin_raw),
    .dout (pin_s)
  );

  // ****************************************************************
  // status byte and read mux
  // ****************************************************************
  always_comb
  begin
    status_byte = {q.reset_cause_code,
                   pin_s[PIN_OV],
                   pin_s[PIN_UV],
                   pin_s[PIN_OTF], pin_s[PIN_OTW],
                   pin_s[PIN_OV] | pin_s[PIN_UV] | pin_s[PIN_OTF]};
  end

  always_comb
  begin
    rd_ok = 1'b1;
    case (gdc_reg_sel(rd_addr))
      SEL_CFG:  rd_data = {3'h0, q.dead_time_select, q.blanking_time_select};
      SEL_STAT: rd_data = status_byte;
      SEL_MODE: rd_data = {7'h00, q.sleep_select};
      SEL_IRQS: rd_data = {3'h0, q.irq_status};
      SEL_IRQM: rd_data = {3'h0, q.irq_mask};
      default:
      begin
        rd_data = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  assign wr_ok  = gdc_reg_sel(wr_addr) != SEL_NONE;
  assign wr_cfg = wr_fire && wr_strb && gdc_reg_sel(wr_addr) == SEL_CFG;
  assign wr_dt  = wr_data[DT_LSB +: DT_W];
  assign wr_bl  = wr_data[BL_LSB +: BL_W];
  assign oe_s   = pin_s[PIN_OE];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    d         = q;
    d.flags   = pin_s[3:0];
    d.shdn_prev = pin_s[PIN_THSD:PIN_UVSD];
    shdn_rise = pin_s[PIN_THSD:PIN_UVSD] & ~q.shdn_prev;
    irq_clr   = '0;
    if (oe_s)
      d.mode = MODE_ACTIVE;
    else if (q.sleep_select)
      d.mode = MODE_SLEEP;
    else
      d.mode = MODE_STANDBY;
    if (wr_fire && wr_strb)
    begin
      case (gdc_reg_sel(wr_addr))
        SEL_CFG:
        begin
          d.dead_time_select = wr_dt;
          if (q.mode == MODE_STANDBY)
            d.blanking_time_select = wr_bl;
          d.reset_cause_code = CAUSE_NORMAL;
        end
        SEL_MODE:
          if (q.mode == MODE_STANDBY)
            d.sleep_select = wr_data[SLEEP_SEL_BIT];
        SEL_IRQS: irq_clr = wr_data[IRQ_W-1:0];
        SEL_IRQM: d.irq_mask = wr_data[IRQ_W-1:0];
        default:  d.irq_mask = q.irq_mask;
      endcase
    end
    if (shdn_rise[1])
      d.reset_cause_code = CAUSE_SLEEP;
    if (shdn_rise[0])
      d.reset_cause_code = CAUSE_UNDERVOLTAGE_SHUTDOWN;
    if (shdn_rise[2])
      d.reset_cause_code = CAUSE_THERMAL;
    if (|shdn_rise)
    begin
      d.dead_time_select     = CFG_RST[DT_LSB +: DT_W];
      d.blanking_time_select = CFG_RST[BL_LSB +: BL_W];
      d.sleep_select         = 1'b0;
    end
    irq_set      = {|shdn_rise, d.flags & ~q.flags};
    d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
    d.dt_cyc     = dt_cycles(d.dead_time_select);
    d.bl_cyc     = bl_cycles(d.blanking_time_select);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= REGS_RST;
    else
      q <= d;
  end

  assign dead_time_cycles  = q.dt_cyc;
  assign blank_time_cycles = q.bl_cyc;
  assign standby_mode      = q.mode == MODE_STANDBY;
  assign sleep_mode        = q.mode == MODE_SLEEP;
  assign irq               = |(q.irq_status & q.irq_mask);

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence cfg_write_s;
    wr_cfg && !(|shdn_rise);
  endsequence

  sequence cfg_write_standby_s;
    cfg_write_s ##0 q.mode == MODE_STANDBY;
  endsequence

  dead_time_map_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_write_s |=> dead_time_cycles == dt_cycles($past(wr_dt)))
    else $error("dead time does not follow written code");

  blank_accept_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_write_standby_s |=> blank_time_cycles == bl_cycles($past(wr_bl)))
    else $error("blanking time does not follow written code");

  blank_guard_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_write_s ##0 q.mode != MODE_STANDBY |=> $stable(blank_time_cycles))
    else $error("blanking changed outside standby");

  cause_uv_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      shdn_rise[0] && !shdn_rise[2] |=> q.reset_cause_code == CAUSE_UNDERVOLTAGE_SHUTDOWN
        && dead_time_cycles == DT_RST_CYC)
    else $error("undervoltage shutdown not recorded");

  ov_flag_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      status_byte[4] == $past(supply_ov_cmp, 2))
    else $error("overvoltage status wrong");

  uv_flag_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      status_byte[3] == $past(supply_uv_cmp, 2))
    else $error("undervoltage status wrong");

  temp_flags_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      status_byte[2] == $past(temp_shutdown_cmp, 2)
        && status_byte[1] == $past(temp_warning_cmp, 2))
    else $error("temperature status wrong");

  fault_sum_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      status_byte[0] == ($past(supply_ov_cmp, 2) || $past(supply_uv_cmp, 2)
        || $past(temp_shutdown_cmp, 2)))
    else $error("fault summary wrong");

  standby_entry_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      !oe_s && !q.sleep_select |=> standby_mode && !sleep_mode)
    else $error("standby not entered");

  cause_por_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> q.reset_cause_code == CAUSE_POR
        && dead_time_cycles == DT_RST_CYC && blank_time_cycles == BL_RST_CYC)
    else $error("reset values wrong");

  cfg_rsvd_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      gdc_reg_sel(rd_addr) == SEL_CFG |-> rd_data[7:5] == 3'h0)
    else $error("config upper bits not zero");

  irq_raise_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      |(irq_set & d.irq_mask) |=> irq)
    else $error("interrupt not raised");

endmodule

// ---- hdl/gdc_pkg.sv ----
package gdc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int DT_BASE_NS    = 2000;
  localparam int DT_STEP_NS    = 250;
  localparam int BL_BASE_NS    = 4000;
  localparam logic [7:0] DT_RST_CYC =
    8'((DT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] BL_RST_CYC = 8'(BL_BASE_NS / CLK_PERIOD_NS);

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam int         AW             = 8;
  localparam logic [7:0] ADDR_CFG       = 8'h00;
  localparam logic [7:0] ADDR_STAT      = 8'h04;
  localparam logic [7:0] ADDR_MODE      = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h10;
  localparam int         DT_LSB         = 2;
  localparam int         DT_W           = 3;
  localparam int         BL_LSB         = 0;
  localparam int         BL_W           = 2;
  localparam int         SLEEP_SEL_BIT  = 0;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [2:0] CAUSE_NORMAL   = 3'h0;
  localparam logic [2:0] CAUSE_POR      = 3'h1;
  localparam logic [2:0] CAUSE_UNDERVOLTAGE_SHUTDOWN   = 3'h2;
  localparam logic [2:0] CAUSE_SLEEP    = 3'h3;
  localparam logic [2:0] CAUSE_THERMAL  = 3'h4;

  // pin vector and interrupt bit positions
  localparam int PIN_OV   = 0;
  localparam int PIN_UV   = 1;
  localparam int PIN_OTF  = 2;
  localparam int PIN_OTW  = 3;
  localparam int PIN_OE   = 4;
  localparam int PIN_UVSD = 5;
  localparam int PIN_SLSD = 6;
  localparam int PIN_THSD = 7;
  localparam int PIN_W    = 8;
  localparam int IRQ_SHDN = 4;
  localparam int IRQ_W    = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_STANDBY, MODE_SLEEP} gdc_mode_e;
  typedef enum logic [2:0] {SEL_CFG, SEL_STAT, SEL_MODE, SEL_IRQS, SEL_IRQM,
                            SEL_NONE} gdc_sel_e;

  function automatic gdc_sel_e gdc_reg_sel(input logic [AW-1:0] addr);
    case (addr)
      ADDR_CFG:      return SEL_CFG;
      ADDR_STAT:     return SEL_STAT;
      ADDR_MODE:     return SEL_MODE;
      ADDR_IRQ_STAT: return SEL_IRQS;
      ADDR_IRQ_MASK: return SEL_IRQM;
      default:       return SEL_NONE;
    endcase
  endfunction

endpackage

// ---- hdl/gdc_sync.sv ----
module gdc_sync
  import gdc_pkg::*;
#(
  parameter int W = PIN_W
)
(
  input  wire logic         aclk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } gdc_sync_s;

  gdc_sync_s q;
  gdc_sync_s d;

  // ****************************************************************
  // two-stage synchroniser
  // ****************************************************************
  always_comb
  begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge aclk)
  begin
    q <= d;
  end

  assign dout = q.s2;

  sync_delay_a: assert property (@(posedge aclk) 1'b1 ##2 (dout == $past(din, 2)))
    else $error("synchroniser output is not the input two cycles back");

endmodule

// ---- hdl/gdc_axil.sv ----
module gdc_axil
  import gdc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic      [1:0]    s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic      [31:0]   s_axi_rdata,
  output logic      [1:0]    s_axi_rresp,
  output logic               wr_fire,
  output logic      [AW-1:0] wr_addr,
  output logic      [7:0]    wr_data,
  output logic               wr_strb,
  input  wire logic          wr_ok,
  output logic      [AW-1:0] rd_addr,
  input  wire logic [7:0]    rd_data,
  input  wire logic          rd_ok
);

  typedef struct packed {
    logic          aw_full;
    logic [AW-1:0] awaddr;
    logic          w_full;
    logic [7:0]    wdata;
    logic          wstrb0;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [7:0]    rdata;
    logic [1:0]    rresp;
  } gdc_axil_s;

  gdc_axil_s q;
  gdc_axil_s d;
  logic      rd_fire;

  // ****************************************************************
  // write and read channels
  // ****************************************************************
  always_comb
  begin
    d       = q;
    wr_fire = q.aw_full && q.w_full && !q.bvalid;
    rd_fire = s_axi_arvalid && !q.rvalid;
    if (s_axi_awvalid && !q.aw_full)
    begin
      d.aw_full = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_full)
    begin
      d.w_full = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (rd_fire)
    begin
      d.rvalid = 1'b1;
      d.rdata  = rd_data;
      d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign s_axi_awready = !q.aw_full;
  assign s_axi_wready  = !q.w_full;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = {24'h000000, q.rdata};
  assign s_axi_rresp   = q.rresp;
  assign wr_addr       = q.awaddr;
  assign wr_data       = q.wdata;
  assign wr_strb       = q.wstrb0;
  assign rd_addr       = s_axi_araddr;

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && s_axi_bresp == $past(wr_ok ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing or wrong");

  read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(rd_data))
    else $error("read data not returned one cycle after address");

endmodule

// ---- tb/test_gate_driver_cfg_status_regs.sv ----
module test_gate_driver_cfg_status_regs
  import gdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk, aresetn, output_enable, standby_mode, sleep_mode, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dead_time_cycles, blank_time_cycles;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, cmp;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  sd;
  int          num_errors = 0;
  int          checks = 0;

  gdc_regs u_gdc_regs
  (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .supply_ov_cmp(cmp[0]), .supply_uv_cmp(cmp[1]),
    .temp_shutdown_cmp(cmp[2]), .temp_warning_cmp(cmp[3]), .output_enable,
    .undervoltage_shutdown(sd[0]), .sleep_shutdown(sd[1]), .thermal_shutdown(sd[2]),
    .dead_time_cycles, .blank_time_cycles, .standby_mode, .sleep_mode, .irq
  );

  always #10 aclk = ~aclk;

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (100)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = '1;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (100)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(r, RESP_OKAY);
    chk(d, e);
  endtask

  function automatic logic [31:0] dt_exp(input int k);
    return 32'((DT_BASE_NS - DT_STEP_NS * k + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [31:0] bl_exp(input int k);
    return 32'((BL_BASE_NS >> k) / CLK_PERIOD_NS);
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(dead_time_cycles, dt_exp(0));
    chk(blank_time_cycles, bl_exp(0));
    chk(standby_mode, 1);
    chk(irq, 0);
    rc(ADDR_CFG, 32'h00);
    rc(ADDR_STAT, 32'h20);
  endtask

  task automatic t_config();
    for (int k = 0; k < 8; k++)
    begin
      wr(ADDR_CFG, 8'(k << 2));
      wt(2);
      chk(dead_time_cycles, dt_exp(k));
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CFG, 8'(k));
      wt(2);
      chk(blank_time_cycles, bl_exp(k));
    end
    wr(ADDR_CFG, 8'hFF);
    rc(ADDR_CFG, 32'h1F);
    rc(ADDR_STAT, 32'h00);
    wr(ADDR_STAT, 8'hFF);
    rc(ADDR_STAT, 32'h00);
  endtask

  task automatic t_standby();
    wr(ADDR_CFG, 8'h01);
    output_enable <= 1'b1;
    wt(4);
    chk(standby_mode, 0);
    chk(sleep_mode, 0);
    wr(ADDR_CFG, 8'h0E);
    rc(ADDR_CFG, 32'h0D);
    wt(2);
    chk(blank_time_cycles, bl_exp(1));
    output_enable <= 1'b0;
    wt(4);
    wr(ADDR_MODE, 8'h01);
    wt(2);
    chk(sleep_mode, 1);
    chk(standby_mode, 0);
    // sleep select locked while asleep; a sleep shutdown clears it
    wr(ADDR_MODE, 8'h00);
    wt(2);
    chk(sleep_mode, 1);
    sd <= 3'h2;
    wt(4);
    sd <= 3'h0;
    wt(5);
    wr(ADDR_IRQ_STAT, 8'h10);
    chk(standby_mode, 1);
    wr(ADDR_CFG, 8'h0E);
    rc(ADDR_CFG, 32'h0E);
    wt(2);
    chk(blank_time_cycles, bl_exp(2));
  endtask

  task automatic t_flags();
    logic [7:0] st [4];
    st = '{8'h11, 8'h09, 8'h05, 8'h02};
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_IRQ_MASK, 8'(1 << i));
      cmp <= 4'(1 << i);
      wt(4);
      rc(ADDR_STAT, 32'(st[i]));
      chk(irq, 1);
      cmp <= 4'h0;
      wt(4);
      rc(ADDR_STAT, 32'h00);
      chk(irq, 1);
      rc(ADDR_IRQ_STAT, 32'(1 << i));
      wr(ADDR_IRQ_MASK, 8'h00);
      chk(irq, 0);
      wr(ADDR_IRQ_STAT, 8'(1 << i));
      rc(ADDR_IRQ_STAT, 32'h00);
    end
  endtask

  task automatic t_shutdown();
    logic [7:0] cs [3];
    cs = '{8'h40, {CAUSE_SLEEP, 5'h0}, {CAUSE_THERMAL, 5'h0}};
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CFG, 8'h1F);
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h10);
      sd <= 3'(1 << i);
      wt(4);
      sd <= 3'h0;
      wt(5);
      rc(ADDR_STAT, 32'(cs[i]));
      rc(ADDR_CFG, 32'h00);
      chk(dead_time_cycles, dt_exp(0));
      chk(standby_mode, 1);
      chk(irq, 1);
      wr(ADDR_IRQ_STAT, 8'h10);
      chk(irq, 0);
    end
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axr(8'h14, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axw(8'h14, 8'h5A, r);
    chk(r, RESP_SLVERR);
  endtask

  // ****************************************************************
  // run
  // ****************************************************************
  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmp, sd, output_enable} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    t_reset();
    t_config();
    t_standby();
    t_flags();
    t_shutdown();
    t_bus();
    results();
  end

endmodule
